// File: logic/sws_pkg.sv
// shared constants and types for the sram write and sleep control block
package sws_pkg;
	// number of byte lanes on the data bus
	localparam int LANES = 4;
	// bits per byte lane
	localparam int LANE_BITS = 9;
	// synchroniser depth for the sleep pin
	localparam int SYNC_STAGES = 3;
	// reset value of the synchroniser chain
	localparam logic [2:0] SYNC_RESET = 3'h0;
	// control states, gray coded along idle -> read -> write
	typedef enum logic [1:0] {
		SWS_IDLE = 2'h0,
		SWS_READ = 2'h1,
		SWS_WRITE = 2'h3,
		SWS_SLEEP = 2'h2
	} sws_state_t;
endpackage : sws_pkg

// File: logic/sws_ctrl.sv
// control logic: chip select decode, write qualification, data bus drive and sleep
`timescale 1ns/100ps
// What this block does
// - selected only when primary enable low, depth high enable high, depth low enable low.
// - full write on global write low, or byte write enable and all lanes low.
// - data bus stays high impedance after a write until a strobe starts a read.
// - data lines are high impedance when leaving sleep.
// - sleep request high enters low power sleep; memory contents are kept.
module sws_ctrl
	import sws_pkg::*;
#(
	parameter int LANE_COUNT = sws_pkg::LANES
)(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// chip enables
	input wire logic CHIP_ENABLE_PRIMARY_N,
	input wire logic CHIP_ENABLE_DEPTH_HI,
	input wire logic CHIP_ENABLE_DEPTH_LO_N,
	// address strobes
	input wire logic PROCESSOR_ADDR_STROBE_N,
	input wire logic CONTROLLER_ADDR_STROBE_N,
	// write controls
	input wire logic GLOBAL_WRITE_N,
	input wire logic BYTE_WRITE_ENABLE_N,
	input wire logic [LANE_COUNT-1:0] LANE_WRITE_N,
	// asynchronous sleep pin
	input wire logic SLEEP_REQUEST,
	// status to the memory core
	output logic SELECTED,
	output logic FULL_WRITE,
	output logic [LANE_COUNT-1:0] LANE_WRITE,
	output logic DATA_OUT_ENABLE,
	output logic SLEEPING
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [SYNC_STAGES-1:0] sync;
		logic sleep;
		sws_state_t state;
		logic oe;
		logic full;
		logic [LANE_COUNT-1:0] lanes;
	} sws_reg_t;

	sws_reg_t r_q;
	sws_reg_t r_d;
	logic sel;
	logic strobe;
	logic wr_any;
	logic wr_full;
	logic [LANE_COUNT-1:0] wr_lane;
	logic start_sleep;
	logic end_sleep;

	// ==========================================================
	// decode
	assign sel = !CHIP_ENABLE_PRIMARY_N && CHIP_ENABLE_DEPTH_HI && !CHIP_ENABLE_DEPTH_LO_N;
	assign strobe = !PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N;
	// lanes write when global write is low or byte enable qualifies each lane
	assign wr_lane = !GLOBAL_WRITE_N ? {LANE_COUNT{1'b1}} :
		(!BYTE_WRITE_ENABLE_N ? ~LANE_WRITE_N : {LANE_COUNT{1'b0}});
	assign wr_full = &wr_lane;
	assign wr_any = |wr_lane;
	// sleep edges are judged only on agreeing second and third stages
	assign start_sleep = r_q.sync[SYNC_STAGES-2] && r_q.sync[SYNC_STAGES-1];
	assign end_sleep = !r_q.sync[SYNC_STAGES-2] && !r_q.sync[SYNC_STAGES-1];

	// ==========================================================
	// next state
	always_comb
	begin
		r_d = r_q;
		r_d.sync = {r_q.sync[SYNC_STAGES-2:0], SLEEP_REQUEST};
		r_d.full = 1'b0;
		r_d.lanes = '0;
		if (r_q.sleep)
		begin
			// accesses ignored, core retains contents while asleep
			if (end_sleep)
			begin
				r_d.sleep = 1'b0;
				r_d.state = SWS_IDLE;
				r_d.oe = 1'b0;
			end
		end
		else if (start_sleep)
		begin
			// the controller has already deselected us; nothing is mid-flight
			r_d.sleep = 1'b1;
			r_d.state = SWS_SLEEP;
			r_d.oe = 1'b0;
		end
		else
		begin
			case (r_q.state)
				SWS_IDLE, SWS_READ, SWS_WRITE:
				begin
					if (sel && strobe && !wr_any)
					begin
						r_d.state = SWS_READ;
						r_d.oe = 1'b1;
					end
					else if (sel && wr_any)
					begin
						r_d.state = SWS_WRITE;
						r_d.oe = 1'b0;
						r_d.full = wr_full;
						r_d.lanes = wr_lane;
					end
				end
				default:
				begin
					r_d.state = SWS_IDLE;
					r_d.oe = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			r_q.sync <= SYNC_RESET;
			r_q.sleep <= 1'b0;
			r_q.state <= SWS_IDLE;
			r_q.oe <= 1'b0;
			r_q.full <= 1'b0;
			r_q.lanes <= '0;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	// outputs; select stays combinational so the core sees it in the access cycle itself
	assign SELECTED = sel && !r_q.sleep;
	assign FULL_WRITE = r_q.full;
	assign LANE_WRITE = r_q.lanes;
	assign DATA_OUT_ENABLE = r_q.oe;
	assign SLEEPING = r_q.sleep;

	// ==========================================================
	// checks
	property p_sel_decode;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SELECTED |-> (!CHIP_ENABLE_PRIMARY_N && CHIP_ENABLE_DEPTH_HI && !CHIP_ENABLE_DEPTH_LO_N);
	endproperty
	a_sel_decode: assert property (p_sel_decode) else $error("select without enables");

	property p_full_write;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!r_q.sleep && !start_sleep && sel && !GLOBAL_WRITE_N) |=> FULL_WRITE;
	endproperty
	a_full_write: assert property (p_full_write) else $error("global write not full");

	property p_hiz_after_write;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(FULL_WRITE || |LANE_WRITE) |-> !DATA_OUT_ENABLE;
	endproperty
	a_hiz_after_write: assert property (p_hiz_after_write) else $error("bus driven after write");

	property p_oe_needs_strobe;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$rose(DATA_OUT_ENABLE) |-> $past(strobe) && $past(sel);
	endproperty
	a_oe_needs_strobe: assert property (p_oe_needs_strobe) else $error("drive without read");

	property p_wake_hiz;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$fell(SLEEPING) |-> !DATA_OUT_ENABLE;
	endproperty
	a_wake_hiz: assert property (p_wake_hiz) else $error("bus driven at wake");

	property p_enter_sleep;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(SLEEP_REQUEST [*4]) |=> SLEEPING;
	endproperty
	a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered");

	property p_sleep_quiet;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SLEEPING |-> !DATA_OUT_ENABLE && !FULL_WRITE && LANE_WRITE == '0 && !SELECTED;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

	property p_wake;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!SLEEP_REQUEST [*4]) |=> !SLEEPING;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep not left");

	// further checks on select, lane qualification, bus drive and sleep
	property p_sel_when_enabled;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!CHIP_ENABLE_PRIMARY_N && CHIP_ENABLE_DEPTH_HI && !CHIP_ENABLE_DEPTH_LO_N && !SLEEPING)
			|-> SELECTED;
	endproperty
	a_sel_when_enabled: assert property (p_sel_when_enabled) else $error("enables not selecting");

	property p_unselected_quiet;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!SELECTED |=> LANE_WRITE == '0 && !FULL_WRITE;
	endproperty
	a_unselected_quiet: assert property (p_unselected_quiet) else $error("write while unselected");

	property p_lane_write;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!r_q.sleep && !start_sleep && sel && GLOBAL_WRITE_N && !BYTE_WRITE_ENABLE_N)
			|=> LANE_WRITE == ~$past(LANE_WRITE_N);
	endproperty
	a_lane_write: assert property (p_lane_write) else $error("lane writes not followed");

	property p_full_by_lanes;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!r_q.sleep && !start_sleep && sel && !BYTE_WRITE_ENABLE_N && LANE_WRITE_N == '0)
			|=> FULL_WRITE;
	endproperty
	a_full_by_lanes: assert property (p_full_by_lanes) else $error("all lanes not full");

	property p_hiz_holds;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!DATA_OUT_ENABLE && !(SELECTED && strobe && !wr_any)) |=> !DATA_OUT_ENABLE;
	endproperty
	a_hiz_holds: assert property (p_hiz_holds) else $error("drive without strobe");

	property p_sleep_no_access;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		SLEEPING |=> LANE_WRITE == '0 && !DATA_OUT_ENABLE;
	endproperty
	a_sleep_no_access: assert property (p_sleep_no_access) else $error("access taken in sleep");
endmodule : sws_ctrl

// File: sim/sws_host.sv
// memory controller model driving the control pins
`timescale 1ns/100ps
module sws_host (
	// clock shared with the block
	input wire logic clk,
	// chip enables
	output logic ep_n,
	output logic eh,
	output logic el_n,
	// strobes and write controls
	output logic sp_n,
	output logic sc_n,
	output logic gw_n,
	output logic bwe_n,
	output logic [3:0] ln_n,
	// sleep pin
	output logic slp
);
	// ====
	// start deselected, strobes and writes released, sleep pin low
	initial
	begin
		idle();
		slp = 1'b0;
	end
	// ====
	// called just after a rising edge; every pin but the sleep pin is set once per call, no glitches
	task pins(input logic p_n, input logic h, input logic l_n, input logic a_n,
		input logic c_n, input logic g_n, input logic b_n, input logic [3:0] w_n);
		ep_n = p_n;
		eh = h;
		el_n = l_n;
		sp_n = a_n;
		sc_n = c_n;
		gw_n = g_n;
		bwe_n = b_n;
		ln_n = w_n;
	endtask : pins
	// released enables deselect the block
	task idle;
		pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf);
	endtask : idle
	// chip enables only, no strobe and no write
	task enables(input logic p_n, input logic h, input logic l_n);
		pins(p_n, h, l_n, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf);
	endtask : enables
	// selected read opened by the processor strobe (0) or the controller strobe (1)
	task read(input logic by_ctrl);
		pins(1'b0, 1'b1, 1'b0, by_ctrl, !by_ctrl, 1'b1, 1'b1, 4'hf);
	endtask : read
	// selected write; lanes follow global write, or byte enable with lane writes
	task write(input logic g_n, input logic b_n, input logic [3:0] w_n);
		pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, g_n, b_n, w_n);
	endtask : write
	// deselect a full cycle ahead so the sleep pin never meets a live access
	task sleep(input logic v);
		idle();
		@(posedge clk);
		#1;
		slp = v;
	endtask : sleep
endmodule : sws_host

// File: sim/sws_tb.sv
// self-checking testbench for the write and sleep control block
`timescale 1ns/100ps
module sync_sram_write_sleep_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic ep_n, eh, el_n, sp_n, sc_n, gw_n, bwe_n, slp, sel, fw, doe, slpg;
	logic [3:0] ln_n, lw, st;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	// ====
	// clock, watchdog, instances
	always #50 clk_sys = ~clk_sys;
	assign st = {sel, fw, doe, slpg};
	// the tests need well under a hundred cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_mismatch++;
			results();
		end
	end
	sws_host u_host (.clk(clk_sys), .ep_n(ep_n), .eh(eh), .el_n(el_n), .sp_n(sp_n), .sc_n(sc_n),
		.gw_n(gw_n), .bwe_n(bwe_n), .ln_n(ln_n), .slp(slp));
	sws_ctrl DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CHIP_ENABLE_PRIMARY_N(ep_n),
		.CHIP_ENABLE_DEPTH_HI(eh), .CHIP_ENABLE_DEPTH_LO_N(el_n),
		.PROCESSOR_ADDR_STROBE_N(sp_n), .CONTROLLER_ADDR_STROBE_N(sc_n),
		.GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_ENABLE_N(bwe_n), .LANE_WRITE_N(ln_n),
		.SLEEP_REQUEST(slp), .SELECTED(sel), .FULL_WRITE(fw), .LANE_WRITE(lw),
		.DATA_OUT_ENABLE(doe), .SLEEPING(slpg));
	// ====
	// shared tasks
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task results;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// ====
	// scenarios; st is select, full write, drive, sleeping
	// every scenario starts just after a rising edge; select is checked 1 ns after driving
	task t_decode;
		for (int i = 0; i < 8; i++)
		begin
			u_host.enables(i[2], i[1], i[0]);
			#1;
			chk(st, {i == 2, 3'h0});
			cyc(1);
		end
		$display("decode done");
	endtask : t_decode
	task t_rw;
		u_host.read(1'b0);
		cyc(1);
		chk(st, 4'ha);
		u_host.write(1'b0, 1'b1, 4'hf);
		cyc(1);
		chk(st, 4'hc);
		chk(lw, 4'hf);
		u_host.enables(1'b0, 1'b1, 1'b0);
		cyc(1);
		chk(st, 4'h8);
		chk(lw, 4'h0);
		cyc(2);
		chk(st, 4'h8);
		u_host.read(1'b1);
		cyc(1);
		chk(st, 4'ha);
		u_host.write(1'b1, 1'b0, 4'h0);
		cyc(1);
		chk(st, 4'hc);
		chk(lw, 4'hf);
		u_host.write(1'b1, 1'b0, 4'ha);
		cyc(1);
		chk(st, 4'h8);
		chk(lw, 4'h5);
		u_host.write(1'b1, 1'b1, 4'h0);
		cyc(1);
		chk(st, 4'h8);
		chk(lw, 4'h0);
		$display("read write done");
	endtask : t_rw
	// the pin passes three flops, so sleep shows four edges after the pin moves
	task t_sleep;
		u_host.read(1'b0);
		cyc(1);
		chk(st, 4'ha);
		u_host.sleep(1'b1);
		cyc(3);
		chk(st, 4'h2);
		cyc(1);
		chk(st, 4'h1);
		u_host.write(1'b0, 1'b1, 4'hf);
		cyc(1);
		chk(st, 4'h1);
		chk(lw, 4'h0);
		u_host.read(1'b1);
		cyc(1);
		chk(st, 4'h1);
		u_host.sleep(1'b0);
		cyc(3);
		chk(st, 4'h1);
		cyc(1);
		chk(st, 4'h0);
		u_host.read(1'b0);
		cyc(1);
		chk(st, 4'ha);
		$display("sleep done");
	endtask : t_sleep
	// reset in mid-run drops the drive; a read held across release is taken at once
	task t_reset;
		u_host.read(1'b1);
		cyc(1);
		chk(st, 4'ha);
		reset_n = 1'b0;
		cyc(2);
		chk(st, 4'h8);
		reset_n = 1'b1;
		cyc(1);
		chk(st, 4'ha);
		cyc(1);
		chk(st, 4'ha);
		u_host.idle();
		cyc(1);
		chk(st, 4'h2);
		$display("reset done");
	endtask : t_reset
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		t_decode();
		t_rw();
		t_sleep();
		t_reset();
		results();
	end
endmodule : sync_sram_write_sleep_ctrl_tb_top
